// ---- core/flash_self_program_control.v ----
// Overview of operation
// - Erase/write to concurrent section sets busy, blocks
// - Busy clears on re-enable after finish, load
// - Signature pattern: load reads signature, store ignored
// - Re-enable only after enable clears, next store
// - No re-enable while programming; aborts buffer load
// - Lock-set store programs locks from R0
// - Load after lock-set reads lock or fuse
// - Page write stores buffer to Z page
// - Stall core for stall-section erase/write
// - Page erase clears Z-addressed page
// - Enable alone loads R1:R0 into buffer word
// - Enable arms four cycles, holds during programming
// - Only five low-bit patterns arm; others ignored
// - Six lock bits, programmed 0, chip erase sets
// - Memory lock mode 2 blocks external programming
// - Memory lock mode 3 blocks programming, verification
// - App pair 10/00 forbids stores to application
// - App pair 00/01 forbids boot loads from application
// - App pair 00/01 masks interrupts with boot vectors
// - Boot pair 10/00 forbids stores to boot
// - Boot pair 00/01 denies reads, masks interrupts
// - Ready request while irq enable and enable clear
`timescale 1ns/1ps
`default_nettype none
`include "flash_self_program_map.vh"

module flash_self_program_control
#(
    parameter PROGRAM_CYCLES = `PROGRAM_CYCLES
)
(
    input wire clk,
    input wire reset,
    input wire clock_enable,
    input wire csr_write,
    input wire [7:0] csr_write_data,
    input wire store_instr,
    input wire load_instr,
    input wire [15:0] z_pointer,
    input wire [7:0] r0,
    input wire [7:0] r1,
    input wire exec_boot,
    input wire vectors_in_boot,
    input wire global_irq_enable,
    input wire chip_erase,
    input wire [7:0] fuse_byte,
    input wire [7:0] signature_byte,
    input wire [7:0] flash_read_byte,
    output reg [7:0] self_program_control_status,
    output reg [7:0] lock_bit_byte,
    output reg [7:0] load_data,
    output reg load_denied,
    output reg core_stall,
    output reg store_ready_irq,
    output reg irq_block,
    output reg external_program_block,
    output reg external_verify_block,
    output reg fuse_locked,
    output reg boot_lock_locked,
    output reg flash_erase,
    output reg flash_write,
    output reg [7:0] flash_page,
    output reg buffer_write,
    output reg [5:0] buffer_word,
    output reg [15:0] buffer_data,
    output reg buffer_discard
);

    localparam ST_IDLE = 2'b00;
    localparam ST_ARMED = 2'b01;
    localparam ST_PROGRAM = 2'b10;

    ////////////////////////////////////////////////////////////////////////

    reg [1:0] state;
    reg [4:0] command;
    reg [2:0] window;
    reg [31:0] prog_count;
    reg section_busy;
    reg irq_enable;
    reg buffer_loaded;
    reg [1:0] next_state;

    wire [4:0] wr_low;
    wire wr_valid;
    wire [7:0] z_page;
    wire target_boot;
    wire store_denied_w;
    wire load_denied_w;
    wire irq_block_w;
    wire ext_prog_w;
    wire ext_ver_w;
    wire fuse_locked_w;
    wire boot_lock_locked_w;
    wire store_take;
    wire in_stall_section;
    wire signature_armed;

    function is_arm_pattern;
        input [5:0] bits;
        begin
            // Signature pattern accepted as reserved-but-documented
            is_arm_pattern = bits[4:0] == `CMD_REENABLE ||
                             bits[4:0] == `CMD_LOCK_SET ||
                             bits[4:0] == `CMD_PAGE_WRITE ||
                             bits[4:0] == `CMD_PAGE_ERASE ||
                             bits[4:0] == `CMD_BUFFER_LOAD ||
                             bits == `CMD_SIGNATURE;
        end
    endfunction

    function page_in_stall;
        input [7:0] page;
        begin
            page_in_stall = page >= `STALL_SECTION_FIRST_PAGE;
        end
    endfunction

    assign wr_low = csr_write_data[4:0];
    assign wr_valid = csr_write && is_arm_pattern(csr_write_data[5:0]);
    assign z_page = z_pointer[14:7];
    assign target_boot = z_page >= `BOOT_SECTION_FIRST_PAGE;
    assign in_stall_section = page_in_stall(z_page);
    assign store_take = state == ST_ARMED && store_instr && window != 3'h0;
    assign signature_armed =
        self_program_control_status[`BIT_SIGNATURE_ROW_READ];

    lock_access_check u_lock
    (
        .lock_byte(lock_bit_byte),
        .target_boot(target_boot),
        .exec_boot(exec_boot),
        .vectors_in_boot(vectors_in_boot),
        .store_denied(store_denied_w),
        .load_denied(load_denied_w),
        .irq_block(irq_block_w),
        .external_program_block(ext_prog_w),
        .external_verify_block(ext_ver_w),
        .fuse_locked(fuse_locked_w),
        .boot_lock_locked(boot_lock_locked_w)
    );

    ////////////////////////////////////////////////////////////////////////

    always @*
    begin
        next_state = state;
        case (state)
            ST_IDLE:
                if (wr_valid)
                    next_state = ST_ARMED;
            ST_ARMED:
                if (store_take &&
                    (command == `CMD_PAGE_ERASE ||
                     command == `CMD_PAGE_WRITE) && !store_denied_w)
                    next_state = ST_PROGRAM;
                else if (store_take || window == 3'h1)
                    next_state = ST_IDLE;
            ST_PROGRAM:
                if (prog_count == 32'h0000_0000)
                    next_state = ST_IDLE;
            default:
                next_state = ST_IDLE;
        endcase
    end

    always @(posedge clk)
    begin
        if (reset)
        begin
            state <= ST_IDLE;
            command <= 5'h00;
            window <= 3'h0;
            prog_count <= 32'h0000_0000;
            section_busy <= 1'b0;
            irq_enable <= 1'b0;
            buffer_loaded <= 1'b0;
            lock_bit_byte <= `LOCK_BYTE_RESET;
            self_program_control_status <= 8'h00;
            load_data <= 8'h00;
            load_denied <= 1'b0;
            core_stall <= 1'b0;
            store_ready_irq <= 1'b0;
            irq_block <= 1'b0;
            external_program_block <= 1'b0;
            external_verify_block <= 1'b0;
            fuse_locked <= 1'b0;
            boot_lock_locked <= 1'b0;
            flash_erase <= 1'b0;
            flash_write <= 1'b0;
            flash_page <= 8'h00;
            buffer_write <= 1'b0;
            buffer_word <= 6'h00;
            buffer_data <= 16'h0000;
            buffer_discard <= 1'b0;
        end
        else if (clock_enable)
        begin
            state <= next_state;
            flash_erase <= 1'b0;
            flash_write <= 1'b0;
            buffer_write <= 1'b0;
            buffer_discard <= 1'b0;
            if (csr_write)
                irq_enable <= csr_write_data[`BIT_STORE_READY_IRQ_ENABLE];
            // Command writes while programming are ignored (bit 7 still loads irq_enable): no re-enable then
            if (state == ST_IDLE && wr_valid)
            begin
                command <= wr_low;
                window <= `STORE_WINDOW_CYCLES;
                if (wr_low == `CMD_REENABLE && buffer_loaded)
                begin
                    buffer_discard <= 1'b1;
                    buffer_loaded <= 1'b0;
                end
            end
            else if (state == ST_ARMED)
                window <= window - 3'h1;
            if (store_take)
            begin
                case (command)
                    `CMD_BUFFER_LOAD:
                        // Signature read shares this code; its store is inert
                        if (!signature_armed)
                        begin
                            buffer_write <= 1'b1;
                            buffer_word <= z_pointer[6:1];
                            buffer_data <= {r1, r0};
                            buffer_loaded <= 1'b1;
                            section_busy <= 1'b0;
                        end
                    `CMD_PAGE_ERASE, `CMD_PAGE_WRITE:
                        if (!store_denied_w)
                        begin
                            flash_erase <= command == `CMD_PAGE_ERASE;
                            flash_write <= command == `CMD_PAGE_WRITE;
                            flash_page <= z_page;
                            prog_count <= PROGRAM_CYCLES - 1;
                            if (command == `CMD_PAGE_WRITE)
                                buffer_loaded <= 1'b0;
                            if (in_stall_section)
                                core_stall <= 1'b1;
                            else
                                section_busy <= 1'b1;
                        end
                    `CMD_LOCK_SET:
                        // Programming only clears bits; R1 and Z unused
                        lock_bit_byte <= lock_bit_byte &
                                         {2'b11, r0[5:0]};
                    `CMD_REENABLE:
                        section_busy <= 1'b0;
                    default:
                        ; // Unreachable: only armed codes get here
                endcase
            end
            if (state == ST_PROGRAM)
            begin
                if (prog_count == 32'h0000_0000)
                    core_stall <= 1'b0;
                else
                    prog_count <= prog_count - 32'h0000_0001;
            end
            if (chip_erase)
                lock_bit_byte <= `LOCK_BYTE_RESET;
            // Loads inside the three cycle window see special bytes
            if (load_instr)
            begin
                if (state == ST_ARMED && window >= 3'h2 &&
                    command == `CMD_LOCK_SET)
                    load_data <= z_pointer[0] ? fuse_byte :
                                 lock_bit_byte;
                else if (state == ST_ARMED && window >= 3'h2 &&
                         command == `CMD_BUFFER_LOAD &&
                         self_program_control_status[5])
                    load_data <= signature_byte;
                else if ((section_busy && !target_boot) || load_denied_w)
                    load_data <= 8'hFF;
                else
                    load_data <= flash_read_byte;
                load_denied <= (section_busy && !in_stall_section) ||
                               load_denied_w;
            end
            if (state == ST_IDLE && wr_valid)
                self_program_control_status <= {irq_enable, section_busy,
                                                csr_write_data[5:0]};
            else if (next_state == ST_IDLE)
                self_program_control_status <= {irq_enable, section_busy,
                                                6'h00};
            else
                self_program_control_status[7:6] <= {irq_enable,
                                                     section_busy};
            store_ready_irq <= irq_enable && global_irq_enable &&
                               next_state == ST_IDLE;
            irq_block <= irq_block_w;
            external_program_block <= ext_prog_w;
            external_verify_block <= ext_ver_w;
            fuse_locked <= fuse_locked_w;
            boot_lock_locked <= boot_lock_locked_w;
        end
    end

endmodule
`default_nettype wire

// ---- core/flash_self_program_map.vh ----
`ifndef FLASH_SELF_PROGRAM_MAP_VH
`define FLASH_SELF_PROGRAM_MAP_VH

// Control/status bit positions
`define BIT_SELF_PROGRAM_ENABLE 0
`define BIT_PAGE_ERASE_CMD 1
`define BIT_PAGE_WRITE_CMD 2
`define BIT_LOCK_BITS_SET_CMD 3
`define BIT_REENABLE 4
`define BIT_SIGNATURE_ROW_READ 5
`define BIT_SECTION_BUSY 6
`define BIT_STORE_READY_IRQ_ENABLE 7

// Low five bit command patterns; signature pattern is six bits
`define CMD_REENABLE 5'h11
`define CMD_LOCK_SET 5'h09
`define CMD_PAGE_WRITE 5'h05
`define CMD_PAGE_ERASE 5'h03
`define CMD_BUFFER_LOAD 5'h01
`define CMD_SIGNATURE 6'h21

// Lock bit byte layout
`define BIT_MEMORY_LOCK_LO 0
`define BIT_MEMORY_LOCK_HI 1
`define BIT_APP_SEC_LOCK_LO 2
`define BIT_APP_SEC_LOCK_HI 3
`define BIT_BOOT_SEC_LOCK_LO 4
`define BIT_BOOT_SEC_LOCK_HI 5
`define LOCK_BYTE_RESET 8'hFF

// Timing
`define STORE_WINDOW_CYCLES 3'h4
`define LOAD_WINDOW_CYCLES 3'h3
`define PROGRAM_TIME_US 4000
`define CLOCK_MHZ 10
`define PROGRAM_CYCLES (`PROGRAM_TIME_US * `CLOCK_MHZ)

// Sections: page index width, first stall-on-write page
`define PAGE_BITS 8
`define WORD_BITS 6
`define STALL_SECTION_FIRST_PAGE 8'hE0
`define BOOT_SECTION_FIRST_PAGE 8'hE0

`endif

// ---- core/lock_access_check.v ----
`timescale 1ns/1ps
`default_nettype none
`include "flash_self_program_map.vh"

module lock_access_check
(
    input wire [7:0] lock_byte,
    input wire target_boot,
    input wire exec_boot,
    input wire vectors_in_boot,
    output wire store_denied,
    output wire load_denied,
    output wire irq_block,
    output wire external_program_block,
    output wire external_verify_block,
    output wire fuse_locked,
    output wire boot_lock_locked
);

    wire [1:0] app_pair;
    wire [1:0] boot_pair;
    wire [1:0] mem_pair;
    wire app_no_store;
    wire app_no_read;
    wire boot_no_store;
    wire boot_no_read;

    assign app_pair = {lock_byte[`BIT_APP_SEC_LOCK_HI],
                       lock_byte[`BIT_APP_SEC_LOCK_LO]};
    assign boot_pair = {lock_byte[`BIT_BOOT_SEC_LOCK_HI],
                        lock_byte[`BIT_BOOT_SEC_LOCK_LO]};
    assign mem_pair = {lock_byte[`BIT_MEMORY_LOCK_HI],
                       lock_byte[`BIT_MEMORY_LOCK_LO]};

    // Pair 10 or 00 forbids stores; 00 or 01 forbids cross reads
    assign app_no_store = ~app_pair[0];
    assign app_no_read = ~app_pair[1];
    assign boot_no_store = ~boot_pair[0];
    assign boot_no_read = ~boot_pair[1];

    assign store_denied = target_boot ? boot_no_store : app_no_store;
    assign load_denied = (target_boot && !exec_boot && boot_no_read) ||
                         (!target_boot && exec_boot && app_no_read);
    assign irq_block = (vectors_in_boot && !exec_boot && app_no_read) ||
                       (!vectors_in_boot && exec_boot && boot_no_read);
    assign external_program_block = mem_pair != 2'b11;
    assign fuse_locked = mem_pair != 2'b11;
    assign external_verify_block = mem_pair == 2'b00;
    assign boot_lock_locked = mem_pair == 2'b00;

endmodule
`default_nettype wire

// ---- verification/core_model.sv ----
`timescale 1ns/1ps
`default_nettype none

module core_model
(
    input wire logic clk,
    input wire logic [7:0] status,
    output logic csr_write,
    output logic [7:0] csr_write_data,
    output logic store_instr,
    output logic load_instr,
    output logic [15:0] z_pointer,
    output logic [7:0] r0,
    output logic [7:0] r1,
    output logic exec_boot,
    output logic vectors_in_boot,
    output logic global_irq_enable,
    output logic chip_erase,
    output logic [7:0] fuse_byte,
    output logic [7:0] signature_byte,
    output logic [7:0] flash_read_byte
);
    initial
    begin
        {csr_write, store_instr, load_instr, chip_erase} = 4'h0;
        {exec_boot, vectors_in_boot, global_irq_enable} = 3'b001;
        {csr_write_data, r0, r1, z_pointer} = 40'h0;
        fuse_byte = 8'h3C;
        signature_byte = 8'hA5;
        flash_read_byte = 8'h69;
    end
    ////////////////////////////////////////////////////////////////////
    // Mode 0 stores, 1 loads, 2 leaves the window idle
    task automatic issue(input logic [7:0] value, input logic [15:0] z,
        input logic [15:0] data, input logic [1:0] mode);
        @(posedge clk);
        csr_write <= 1'b1;
        csr_write_data <= value;
        @(posedge clk);
        csr_write <= 1'b0;
        z_pointer <= z;
        {r1, r0} <= data;
        store_instr <= (mode == 2'd0);
        load_instr <= (mode == 2'd1);
        @(posedge clk);
        store_instr <= 1'b0;
        load_instr <= 1'b0;
        // Released operands must not keep looking valid
        z_pointer <= ~z;
        {r1, r0} <= ~data;
        @(negedge clk);
        // Without a store the window stays open and refuses new writes
        if (mode != 2'd0)
            repeat (2) @(negedge clk);
    endtask
    task automatic wait_ready;
        for (int i = 0; i < 40 && status[0]; i++)
            @(negedge clk);
    endtask
    task automatic wipe_locks;
        @(posedge clk);
        chip_erase <= 1'b1;
        @(posedge clk);
        chip_erase <= 1'b0;
        @(negedge clk);
    endtask
endmodule

`default_nettype wire

// ---- verification/flash_self_program_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none

module flash_self_program_checker
(
    input wire logic clk,
    input wire logic reset,
    input wire logic store_instr,
    input wire logic [15:0] z_pointer,
    input wire logic [7:0] r0,
    input wire logic [7:0] r1,
    input wire logic global_irq_enable,
    input wire logic chip_erase,
    input wire logic [7:0] self_program_control_status,
    input wire logic [7:0] lock_bit_byte,
    input wire logic core_stall,
    input wire logic store_ready_irq,
    input wire logic external_verify_block,
    input wire logic flash_erase,
    input wire logic flash_write,
    input wire logic [7:0] flash_page,
    input wire logic buffer_write,
    input wire logic [5:0] buffer_word,
    input wire logic [15:0] buffer_data
);
    wire logic [7:0] st = self_program_control_status;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);
    sequence idle_armed;
        st[5:0] == 6'h01 && !store_instr;
    endsequence
    sequence load_store;
        st[5:0] == 6'h01 && store_instr;
    endsequence
    stall_core_a: assert property (
        (flash_erase || flash_write) && flash_page >= 8'hE0
        |-> ##[0:1] core_stall) else $error("stall missing");
    buffer_load_a: assert property (load_store |=> buffer_write
        && buffer_word == $past(z_pointer[6:1])
        && buffer_data == {$past(r1), $past(r0)})
        else $error("buffer load wrong");
    enable_timeout_a: assert property (idle_armed [*4] |=> !st[0])
        else $error("enable outlived window");
    ready_irq_a: assert property (
        (st[7] && !st[0] && global_irq_enable) [*2] |-> store_ready_irq)
        else $error("ready request missing");
    lock_program_a: assert property (
        store_instr && st[5:0] == 6'h09 |=> lock_bit_byte[5:0]
        == ($past(lock_bit_byte[5:0]) & $past(r0[5:0])))
        else $error("lock byte not from r0");
    lock_keep_a: assert property (!chip_erase
        |=> (lock_bit_byte & ~$past(lock_bit_byte)) == 8'h00)
        else $error("lock bit returned to one");
    mode_three_a: assert property (
        (lock_bit_byte[1:0] == 2'b00) [*2] |-> external_verify_block)
        else $error("verify not blocked");
    app_store_deny_a: assert property (store_instr
        && st[5:0] == 6'h03 && !lock_bit_byte[2]
        && z_pointer[14:7] < 8'hE0 |=> !flash_erase)
        else $error("locked page erased");
endmodule

bind flash_self_program_control flash_self_program_checker i_checker (
    .clk(clk), .reset(reset), .store_instr(store_instr),
    .z_pointer(z_pointer), .r0(r0), .r1(r1),
    .global_irq_enable(global_irq_enable), .chip_erase(chip_erase),
    .self_program_control_status(self_program_control_status),
    .lock_bit_byte(lock_bit_byte), .core_stall(core_stall),
    .store_ready_irq(store_ready_irq),
    .external_verify_block(external_verify_block),
    .flash_erase(flash_erase), .flash_write(flash_write),
    .flash_page(flash_page), .buffer_write(buffer_write),
    .buffer_word(buffer_word), .buffer_data(buffer_data)
);

`default_nettype wire

// ---- verification/test_flash_self_program_control.sv ----
`timescale 1ns/1ps
`default_nettype none

module test_flash_self_program_control;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic load_seen = 1'b0;
    int errors = 0;
    int checks = 0;
    integer seed = 32'h6505bff0;
    logic [15:0] z, data;
    logic [27:0] q[$];
    logic [7:0] bad[5] = '{8'h07, 8'h13, 8'h0D, 8'h19, 8'h02};
    wire logic csr_write, store_instr, load_instr, exec_boot;
    wire logic vectors_in_boot, global_irq_enable, chip_erase;
    wire logic [7:0] csr_write_data, r0, r1, fuse_byte, signature_byte;
    wire logic [7:0] flash_read_byte, status, lock_bit_byte, load_data;
    wire logic [7:0] flash_page;
    wire logic [15:0] z_pointer, buffer_data;
    wire logic [5:0] buffer_word;
    wire logic load_denied, core_stall, store_ready_irq, flash_erase;
    wire logic flash_write, buffer_write, external_verify_block;
    wire logic irq_block, external_program_block, fuse_locked;
    wire logic boot_lock_locked, buffer_discard;

    always #50 clk = ~clk;
    core_model i_core_model (.clk(clk), .status(status),
        .csr_write(csr_write), .csr_write_data(csr_write_data),
        .store_instr(store_instr), .load_instr(load_instr),
        .z_pointer(z_pointer), .r0(r0), .r1(r1), .exec_boot(exec_boot),
        .vectors_in_boot(vectors_in_boot), .chip_erase(chip_erase),
        .global_irq_enable(global_irq_enable), .fuse_byte(fuse_byte),
        .signature_byte(signature_byte),
        .flash_read_byte(flash_read_byte));
    flash_self_program_control #(.PROGRAM_CYCLES(8))
        i_flash_self_program_control (.clk(clk), .reset(reset),
        .clock_enable(1'b1), .csr_write(csr_write),
        .csr_write_data(csr_write_data), .store_instr(store_instr),
        .load_instr(load_instr), .z_pointer(z_pointer), .r0(r0),
        .r1(r1), .exec_boot(exec_boot), .chip_erase(chip_erase),
        .vectors_in_boot(vectors_in_boot), .fuse_byte(fuse_byte),
        .global_irq_enable(global_irq_enable),
        .signature_byte(signature_byte),
        .flash_read_byte(flash_read_byte),
        .self_program_control_status(status),
        .lock_bit_byte(lock_bit_byte), .load_data(load_data),
        .load_denied(load_denied), .core_stall(core_stall),
        .store_ready_irq(store_ready_irq), .irq_block(irq_block),
        .external_program_block(external_program_block),
        .external_verify_block(external_verify_block),
        .fuse_locked(fuse_locked), .boot_lock_locked(boot_lock_locked),
        .flash_erase(flash_erase),
        .flash_write(flash_write), .flash_page(flash_page),
        .buffer_write(buffer_write), .buffer_word(buffer_word),
        .buffer_data(buffer_data), .buffer_discard(buffer_discard));
    ////////////////////////////////////////////////////////////////////
    task automatic note(input logic [3:0] kind, input logic [23:0] value);
        q.push_back({kind, value});
    endtask
    task automatic compare_note(input logic [27:0] actual);
        checks++;
        if (q.size() == 0 || actual !== q[0])
        begin
            errors++;
            $display("Error at %0t: result %h unexpected", $time, actual);
        end
        if (q.size() != 0)
            void'(q.pop_front());
    endtask
    task automatic compare_level(input logic [7:0] actual,
        input logic [7:0] expected);
        checks++;
        if (actual !== expected)
        begin
            errors++;
            $display("Error at %0t: %h not %h", $time, actual, expected);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////
    always @(posedge clk)
        load_seen <= load_instr;
    always @(negedge clk)
    begin
        if (buffer_write === 1'b1)
            compare_note({4'h0, 2'b00, buffer_word, buffer_data});
        if (flash_erase === 1'b1)
            compare_note({4'h1, 16'h0000, flash_page});
        if (flash_write === 1'b1)
            compare_note({4'h2, 16'h0000, flash_page});
        if (buffer_discard === 1'b1)
            compare_note({4'h4, 24'h00_0000});
        if (load_seen === 1'b1)
            compare_note({4'h3, 7'h00, load_denied, 8'h00, load_data});
    end
    initial
    begin
        #(5000 * 100);
        errors++;
        tally_and_finish;
    end
    ////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        @(negedge clk);
        compare_level(status, 8'h00);
        compare_level(lock_bit_byte, 8'hFF);
        for (int i = 0; i < 4; i++)
        begin
            data = 16'($random(seed));
            z = 16'($random(seed));
            note(4'h0, {2'b00, z[6:1], data});
            i_core_model.issue(8'h01, z, data, 2'd0);
            compare_level(status & 8'h01, 8'h00);
        end
        i_core_model.issue(8'h01, z, data, 2'd2);
        repeat (4) @(negedge clk);
        compare_level(status & 8'h01, 8'h00);
        i_core_model.issue(8'h00, z, data, 2'd0);
        foreach (bad[i])
        begin
            i_core_model.issue(bad[i], z, data, 2'd0);
            compare_level(status & 8'h3F, 8'h00);
        end
        note(4'h1, {16'h0000, 8'h10});
        i_core_model.issue(8'h03, 16'h0800, data, 2'd0);
        i_core_model.issue(8'h11, 16'h0000, data, 2'd2);
        compare_level(status & 8'h50, 8'h40);
        compare_level(core_stall, 1'b0);
        i_core_model.wait_ready;
        compare_level(status & 8'h41, 8'h40);
        note(4'h4, 24'h00_0000);
        i_core_model.issue(8'h11, 16'h0000, data, 2'd0);
        @(negedge clk);
        compare_level(status & 8'h40, 8'h00);
        note(4'h2, {16'h0000, 8'hE5});
        i_core_model.issue(8'h05, 16'h7280, data, 2'd0);
        compare_level(core_stall, 1'b1);
        i_core_model.wait_ready;
        @(negedge clk);
        compare_level(core_stall, 1'b0);
        note(4'h1, {16'h0000, 8'h10});
        i_core_model.issue(8'h03, 16'h0800, data, 2'd0);
        i_core_model.wait_ready;
        note(4'h0, {8'h00, data});
        i_core_model.issue(8'h01, 16'h0000, data, 2'd0);
        @(negedge clk);
        compare_level(status & 8'h40, 8'h00);
        note(4'h3, {16'h0000, 8'h69});
        i_core_model.issue(8'h00, 16'h0801, data, 2'd1);
        note(4'h3, {16'h0000, 8'hFF});
        i_core_model.issue(8'h09, 16'h0000, data, 2'd1);
        note(4'h3, {16'h0000, 8'h3C});
        i_core_model.issue(8'h09, 16'h0001, data, 2'd1);
        note(4'h3, {16'h0000, 8'hA5});
        i_core_model.issue(8'h21, 16'h0000, data, 2'd1);
        i_core_model.issue(8'h21, 16'h0800, data, 2'd0);
        i_core_model.issue(8'h09, 16'h0000, 16'h00F3, 2'd0);
        compare_level(lock_bit_byte, 8'hF3);
        i_core_model.issue(8'h03, 16'h0800, data, 2'd0);
        @(posedge clk);
        i_core_model.exec_boot <= 1'b1;
        note(4'h3, {16'h0100, 8'hFF});
        i_core_model.issue(8'h00, 16'h0800, data, 2'd1);
        @(posedge clk);
        i_core_model.exec_boot <= 1'b0;
        i_core_model.vectors_in_boot <= 1'b1;
        i_core_model.issue(8'h09, 16'h0000, 16'h00FC, 2'd0);
        repeat (2) @(negedge clk);
        compare_level(lock_bit_byte, 8'hF0);
        compare_level(external_verify_block, 1'b1);
        compare_level({irq_block, external_program_block, fuse_locked,
            boot_lock_locked}, 8'h0F);
        i_core_model.wipe_locks;
        compare_level(lock_bit_byte, 8'hFF);
        i_core_model.issue(8'h80, 16'h0000, data, 2'd2);
        compare_level(store_ready_irq, 1'b1);
        compare_level(8'(q.size()), 8'h00);
        tally_and_finish;
    end
endmodule

`default_nettype wire
